//--- dv/lsa_link_props.sv
`timescale 1ns/10ps
`default_nettype none
`include "lsa_params.svh"
module lsa_link_props (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic scl_oe_m,
  input wire logic sda_oe_m,
  input wire logic sda_oe_s,
  input wire logic scl,
  input wire logic sda
);
  localparam int QTR = `LSA_QTR_CYC;
  logic [15:0] low_cnt;
  logic [15:0] high_cnt;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // saturating run lengths, so a long idle never wraps
  always_ff @(posedge clk_i) begin
    if (rst_i || scl) low_cnt <= 16'h0;
    else if (~&low_cnt) low_cnt <= low_cnt + 16'h1;
  end
  always_ff @(posedge clk_i) begin
    if (rst_i || !scl) high_cnt <= 16'h0;
    else if (~&high_cnt) high_cnt <= high_cnt + 16'h1;
  end
  sequence s_start;
    scl && $fell(sda);
  endsequence
  sequence s_stop;
    scl && $rose(sda);
  endsequence
  a_dev_sda_stable: assert property (scl && $past(scl) |-> $stable(sda_oe_s))
    else $error("device moved sda while scl high");
  a_host_sda_hold: assert property ($rose(scl) |=> $stable(sda_oe_m)[*8])
    else $error("host moved sda just after scl rise");
  a_scl_low_min: assert property ($rose(scl) |-> low_cnt >= 2 * QTR - 4)
    else $error("scl low phase too short");
  a_scl_high_min: assert property ($rose(scl_oe_m) |-> high_cnt >= 2 * QTR - 4)
    else $error("scl high phase too short");
  a_start_setup: assert property (s_start |-> high_cnt >= QTR - 4)
    else $error("start without settled scl high");
  a_stop_setup: assert property (s_stop |-> high_cnt >= QTR - 4)
    else $error("stop without settled scl high");
  a_dev_ack_low: assert property ($rose(sda_oe_s) |-> (!scl)[*4])
    else $error("device took sda outside scl low");
  a_dev_idle_quiet: assert property (high_cnt > 4 * QTR |-> !sda_oe_s)
    else $error("device drives sda on idle bus");
endmodule // lsa_link_props
`default_nettype wire

//--- dv/tb_i2c_slave_limit_alert_regs.sv
`timescale 1ns/10ps
`default_nettype none
module tb_i2c_slave_limit_alert_regs;
  import lsa_pkg::*;
  typedef struct packed {logic [31:0] m; logic [31:0] v;} lsa_note_t;
  localparam logic [4:0] ST = 5'h01;
  localparam logic [4:0] SP = 5'h02;
  localparam logic [4:0] WR = 5'h04;
  localparam logic [4:0] RD = 5'h08;
  localparam logic [4:0] NK = 5'h10;
  localparam logic [6:0] ADR = 7'h2a;
  logic clk_i, rst_i, wb_cyc, wb_stb, wb_we, wb_ack, want, asamp;
  logic res_valid, alert_pin;
  logic [3:0] wb_adr, wb_sel, alert_ch;
  logic [31:0] wb_wdat, wb_rdat, seed, q;
  logic [1:0] res_ch;
  logic [11:0] res_data;
  int error_cnt, tests_run;
  lsa_note_t note_q[$];
  lsa_note_t alert_q[$];
  lsa_strap_t strap_hi, strap_lo;
  lsa_i2c_if i_lsa_i2c_if ();
  lsa_dev i_lsa_dev (
    .clk_i(clk_i), .rst_i(rst_i), .bus(i_lsa_i2c_if),
    .addr_strap_hi_i(strap_hi), .addr_strap_lo_i(strap_lo),
    .res_valid_i(res_valid), .res_ch_i(res_ch), .res_data_i(res_data),
    .alert_output_pin_o(alert_pin), .alert_ch_o(alert_ch)
  );
  lsa_host i_lsa_host (
    .clk_i(clk_i), .rst_i(rst_i), .bus(i_lsa_i2c_if),
    .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
    .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat),
    .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack)
  );
  lsa_link_props i_lsa_link_props (
    .clk_i(clk_i), .rst_i(rst_i),
    .scl_oe_m(i_lsa_i2c_if.scl_oe_m), .sda_oe_m(i_lsa_i2c_if.sda_oe_m),
    .sda_oe_s(i_lsa_i2c_if.sda_oe_s), .scl(i_lsa_i2c_if.scl),
    .sda(i_lsa_i2c_if.sda)
  );
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  task automatic finish_test();
    $display("errors %0d comparisons %0d", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input lsa_note_t n);
    tests_run++;
    if ((got & n.m) !== n.v) begin
      error_cnt++;
      $display("unexpected at %0t: got %h want %h", $time, got & n.m, n.v);
    end
  endtask
  task automatic check_rd(input logic [31:0] got);
    cmp(got, note_q.pop_front());
  endtask
  task automatic check_alert(input logic [31:0] got);
    cmp(got, alert_q.pop_front());
  endtask
  // one wishbone classic cycle, held until ack is sampled
  task automatic wb_io(input logic we, input logic [3:0] a,
                       input logic [31:0] d, input logic chk,
                       output logic [31:0] r);
    @(posedge clk_i);
    {wb_cyc, wb_stb, wb_we, wb_adr, wb_wdat, want} <= {2'b11, we, a, d, chk};
    do @(posedge clk_i); while (wb_ack !== 1'b1);
    r = wb_rdat;
    {wb_cyc, wb_stb, want} <= 3'b000;
  endtask
  // one bus step; busy is polled since commands while busy are dropped
  task automatic xfer(input logic [4:0] fl, input logic [7:0] b,
                      input logic [31:0] m, input logic [31:0] v);
    logic [31:0] r;
    wb_io(1'b1, 4'h0, {19'h0, fl, b}, 1'b0, r);
    r = 32'h1;
    while (r[0] !== 1'b0) wb_io(1'b0, 4'h4, 32'h0, 1'b0, r);
    note_q.push_back('{m, v});
    wb_io(1'b0, 4'h4, 32'h0, 1'b1, r);
  endtask
  task automatic result(input logic [1:0] ch, input logic [11:0] d,
                        input logic [4:0] exp);
    @(posedge clk_i);
    {res_valid, res_ch, res_data} <= {1'b1, ch, d};
    @(posedge clk_i);
    res_valid <= 1'b0;
    repeat (4) @(posedge clk_i);
    alert_q.push_back('{32'h1f, {27'h0, exp}});
    asamp <= 1'b1;
    @(posedge clk_i);
    asamp <= 1'b0;
  endtask
  always @(posedge clk_i) begin
    if (wb_ack === 1'b1 && want) check_rd(wb_rdat);
    if (asamp) check_alert({27'h0, alert_pin, alert_ch});
  end
  initial begin
    // traffic needs under 90k cycles; anything longer is a hang
    repeat (100000) @(posedge clk_i);
    error_cnt++;
    finish_test();
  end
  initial begin
    {rst_i, wb_cyc, wb_stb, wb_we, want, asamp, res_valid} = 7'h40;
    {wb_adr, wb_sel, wb_wdat, res_ch, res_data} = {4'h0, 4'hf, 46'h0};
    seed = 32'd830;
    strap_hi = strap_float;
    strap_lo = strap_float;
    error_cnt = 0;
    tests_run = 0;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (30) @(posedge clk_i);
    // whole-range default window: no value may alert
    for (int i = 0; i < 4; i++) begin
      seed = xs(seed);
      result(2'h2, seed[11:0], 5'h00);
    end
    note_q.push_back('{32'hffffffff, 32'h0});
    wb_io(1'b0, 4'hc, 32'h0, 1'b1, q);
    xfer(ST | WR, {ADR, 1'b0}, 32'h2, 32'h0);
    xfer(WR, 8'h14, 32'h2, 32'h0);
    xfer(ST | WR, {ADR, 1'b1}, 32'h2, 32'h0);
    xfer(RD, 8'h0, 32'hff00, 32'h0f00);
    xfer(RD | NK | SP, 8'h0, 32'hff00, 32'hff00);
    xfer(ST | WR, {ADR, 1'b0}, 32'h2, 32'h0);
    xfer(WR, 8'h14, 32'h2, 32'h0);
    xfer(WR, 8'hf1, 32'h2, 32'h0);
    xfer(WR | SP, 8'h23, 32'h2, 32'h0);
    xfer(ST | WR, {ADR, 1'b1}, 32'h2, 32'h0);
    xfer(RD, 8'h0, 32'hff00, 32'h0100);
    xfer(RD | NK | SP, 8'h0, 32'hff00, 32'h2300);
    result(2'h0, 12'h123, 5'h00);
    result(2'h0, 12'h124, 5'h11);
    // all-ones margin means the alert can never release
    result(2'h0, 12'h000, 5'h11);
    xfer(ST | WR | SP, {7'h20, 1'b0}, 32'h2, 32'h2);
    // second reset with other straps: low/high gives 0x2c
    @(posedge clk_i);
    {strap_hi, strap_lo} <= {strap_low, strap_high};
    rst_i <= 1'b1;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (30) @(posedge clk_i);
    // upper bound back at all ones, alert cleared by reset
    result(2'h0, 12'h124, 5'h00);
    xfer(ST | WR | SP, {7'h2c, 1'b0}, 32'h2, 32'h0);
    finish_test();
  end
endmodule // tb_i2c_slave_limit_alert_regs
`default_nettype wire

//--- pkg/lsa_i2c_if.sv
`timescale 1ns/10ps
`default_nettype none
interface lsa_i2c_if;
  logic scl_oe_m;
  logic sda_oe_m;
  logic sda_oe_s;
  logic scl;
  logic sda;
  // open drain: an enable pulls the wire low
  assign scl = ~scl_oe_m;
  assign sda = ~(sda_oe_m | sda_oe_s);
  modport host (output scl_oe_m, output sda_oe_m, input scl, input sda);
  modport dev (output sda_oe_s, input scl, input sda);
endinterface
`default_nettype wire

//--- pkg/lsa_params.svh
`ifndef LSA_PARAMS_SVH
`define LSA_PARAMS_SVH
`define LSA_CLK_NS 4
`define LSA_SPIKE_NS 50
`define LSA_SPIKE_CYC ((`LSA_SPIKE_NS + `LSA_CLK_NS - 1) / `LSA_CLK_NS)
`define LSA_QTR_NS 625
`define LSA_QTR_CYC (`LSA_QTR_NS / `LSA_CLK_NS)
`define LSA_ADDR_PREFIX 3'h2
`define LSA_CH_NUM 4
`define LSA_FIELD_W 12
`define LSA_LOWER_RST 12'h000
`define LSA_UPPER_RST 12'hfff
`define LSA_MARGIN_RST 12'hfff
`define LSA_PTR_LOWER 8'h10
`define LSA_PTR_UPPER 8'h14
`define LSA_PTR_MARGIN 8'h18
`define LSA_ACK_BIT 4'h8
`define LSA_POST_ACK 4'h9
`define LSA_STRAP_WAIT 2'h3
`define LSA_WB_CMD 4'h0
`define LSA_WB_STAT 4'h4
`define LSA_CMD_START 8
`define LSA_CMD_STOP 9
`define LSA_CMD_WRITE 10
`define LSA_CMD_READ 11
`define LSA_CMD_NACK 12
`define LSA_STAT_BUSY 0
`define LSA_STAT_NACK 1
`define LSA_STAT_RX 8
`endif

//--- pkg/lsa_pkg.sv
`default_nettype none
package lsa_pkg;
  typedef enum logic [1:0] {strap_high, strap_float, strap_low} lsa_strap_t;
  typedef enum logic [2:0] {
    s_idle, s_addr, s_ptr, s_msb, s_lsb, s_tx
  } lsa_slv_st_t;
  typedef enum logic [1:0] {m_idle, m_start, m_byte, m_stop} lsa_mst_st_t;
endpackage
`default_nettype wire

//--- rtl/lsa_dev.sv
`timescale 1ns/10ps
`default_nettype none
`include "lsa_params.svh"
module lsa_dev (
  input wire logic clk_i,
  input wire logic rst_i,
  lsa_i2c_if.dev bus,
  input wire lsa_pkg::lsa_strap_t addr_strap_hi_i,
  input wire lsa_pkg::lsa_strap_t addr_strap_lo_i,
  input wire logic res_valid_i,
  input wire logic [1:0] res_ch_i,
  input wire logic [11:0] res_data_i,
  output logic alert_output_pin_o,
  output logic [3:0] alert_ch_o
);
  import lsa_pkg::*;

  logic scl_f;
  logic sda_f;
  logic scl_d_reg;
  logic sda_d_reg;
  logic scl_rise;
  logic scl_fall;
  logic start_ev;
  logic stop_ev;
  lsa_strap_t hi_meta_reg;
  lsa_strap_t hi_sync_reg;
  lsa_strap_t lo_meta_reg;
  lsa_strap_t lo_sync_reg;
  logic [1:0] cap_cnt_reg;
  logic [6:0] my_addr_reg;
  lsa_slv_st_t st_reg;
  logic [3:0] bit_reg;
  logic [7:0] rx_reg;
  logic [7:0] tx_reg;
  logic [7:0] ptr_reg;
  logic [7:0] msb_reg;
  logic tx_lsb_reg;
  logic sda_oe_reg;
  logic byte_end;
  logic wr_en;
  logic [15:0] rd_word;
  logic [7:0] tx_byte;
  logic [11:0] lower_reg [`LSA_CH_NUM];
  logic [11:0] upper_reg [`LSA_CH_NUM];
  logic [11:0] margin_reg [`LSA_CH_NUM];
  logic [3:0] alert_reg;
  logic alert_pin_reg;

  // strap code to address bits: high 00, floating 10, low 11
  function automatic logic [1:0] strap_bits(input lsa_strap_t s);
    case (s)
      strap_high: strap_bits = 2'h0;
      strap_float: strap_bits = 2'h2;
      default: strap_bits = 2'h3;
    endcase
  endfunction

  function automatic logic [15:0] reg_read(input logic [7:0] p);
    logic [11:0] f;
    f = 12'h000;
    case (p[7:2])
      6'(`LSA_PTR_LOWER >> 2): f = lower_reg[p[1:0]];
      6'(`LSA_PTR_UPPER >> 2): f = upper_reg[p[1:0]];
      6'(`LSA_PTR_MARGIN >> 2): f = margin_reg[p[1:0]];
      default: f = 12'h000;
    endcase
    reg_read = {4'h0, f};
  endfunction

  lsa_line_filt u_scl_filt (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .line_i(bus.scl),
    .line_o(scl_f)
  );
  lsa_line_filt u_sda_filt (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .line_i(bus.sda),
    .line_o(sda_f)
  );

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end else begin
      scl_d_reg <= scl_f;
      sda_d_reg <= sda_f;
    end
  end

  assign scl_rise = scl_f & ~scl_d_reg;
  assign scl_fall = ~scl_f & scl_d_reg;
  assign start_ev = scl_f & scl_d_reg & sda_d_reg & ~sda_f;
  assign stop_ev = scl_f & scl_d_reg & ~sda_d_reg & sda_f;
  assign byte_end = scl_fall && bit_reg == `LSA_ACK_BIT;
  assign wr_en = byte_end && st_reg == s_lsb;
  assign rd_word = reg_read(ptr_reg);
  assign tx_byte = tx_lsb_reg ? rd_word[7:0] : rd_word[15:8];
  // the clock line is never driven here, so no stretching
  assign bus.sda_oe_s = sda_oe_reg;

  always_ff @(posedge clk_i) begin
    hi_meta_reg <= addr_strap_hi_i;
    hi_sync_reg <= hi_meta_reg;
    lo_meta_reg <= addr_strap_lo_i;
    lo_sync_reg <= lo_meta_reg;
  end

  // straps are latched once, a few cycles after reset release
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cap_cnt_reg <= 2'h0;
      my_addr_reg <= {`LSA_ADDR_PREFIX, 4'hf};
    end else if (cap_cnt_reg != `LSA_STRAP_WAIT) begin
      cap_cnt_reg <= cap_cnt_reg + 2'h1;
      my_addr_reg <= {`LSA_ADDR_PREFIX,
        strap_bits(hi_sync_reg), strap_bits(lo_sync_reg)};
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_reg <= s_idle;
      bit_reg <= 4'h0;
      rx_reg <= 8'h00;
      tx_reg <= 8'h00;
      ptr_reg <= 8'h00;
      msb_reg <= 8'h00;
      tx_lsb_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
    end else if (start_ev) begin
      st_reg <= s_addr;
      bit_reg <= 4'h0;
      sda_oe_reg <= 1'b0;
    end else if (stop_ev) begin
      st_reg <= s_idle;
      sda_oe_reg <= 1'b0;
    end else if (st_reg != s_idle) begin
      if (scl_rise) begin
        if (bit_reg < `LSA_ACK_BIT) begin
          rx_reg <= {rx_reg[6:0], sda_f};
          bit_reg <= bit_reg + 4'h1;
        end else begin
          bit_reg <= `LSA_POST_ACK;
          if (st_reg == s_tx && sda_f)
            st_reg <= s_idle;
        end
      end else if (byte_end) begin
        case (st_reg)
          s_addr: begin
            // prefix 010 means address zero never matches
            if (rx_reg[7:1] == my_addr_reg) begin
              sda_oe_reg <= 1'b1;
              st_reg <= rx_reg[0] ? s_tx : s_ptr;
              tx_lsb_reg <= 1'b0;
            end else begin
              st_reg <= s_idle;
            end
          end
          s_ptr: begin
            ptr_reg <= rx_reg;
            sda_oe_reg <= 1'b1;
            st_reg <= s_msb;
          end
          s_msb: begin
            msb_reg <= rx_reg;
            sda_oe_reg <= 1'b1;
            st_reg <= s_lsb;
          end
          s_lsb: begin
            sda_oe_reg <= 1'b1;
            st_reg <= s_ptr;
          end
          s_tx: sda_oe_reg <= 1'b0;
          default: st_reg <= s_idle;
        endcase
      end else if (scl_fall) begin
        if (bit_reg == `LSA_POST_ACK) begin
          bit_reg <= 4'h0;
          if (st_reg == s_tx) begin
            tx_reg <= tx_byte;
            sda_oe_reg <= ~tx_byte[7];
            tx_lsb_reg <= ~tx_lsb_reg;
          end else begin
            sda_oe_reg <= 1'b0;
          end
        end else if (bit_reg != 4'h0 && st_reg == s_tx) begin
          tx_reg <= {tx_reg[6:0], 1'b0};
          sda_oe_reg <= ~tx_reg[6];
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < `LSA_CH_NUM; i++) begin
        lower_reg[i] <= `LSA_LOWER_RST;
        upper_reg[i] <= `LSA_UPPER_RST;
        margin_reg[i] <= `LSA_MARGIN_RST;
      end
    end else if (wr_en) begin
      // high nibble of the write is dropped
      case (ptr_reg[7:2])
        6'(`LSA_PTR_LOWER >> 2): lower_reg[ptr_reg[1:0]] <=
          {msb_reg[3:0], rx_reg};
        6'(`LSA_PTR_UPPER >> 2): upper_reg[ptr_reg[1:0]] <=
          {msb_reg[3:0], rx_reg};
        6'(`LSA_PTR_MARGIN >> 2): margin_reg[ptr_reg[1:0]] <=
          {msb_reg[3:0], rx_reg};
        default: ;
      endcase
    end
  end

  // 13-bit sums so a large margin cannot wrap into the window
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      alert_reg <= 4'h0;
    end else if (res_valid_i) begin
      for (int i = 0; i < `LSA_CH_NUM; i++) begin
        if (res_ch_i == 2'(i)) begin
          if (res_data_i < lower_reg[i] ||
              res_data_i > upper_reg[i]) begin
            alert_reg[i] <= 1'b1;
          end else if ({1'b0, res_data_i} >=
              {1'b0, lower_reg[i]} + {1'b0, margin_reg[i]} &&
              {1'b0, res_data_i} + {1'b0, margin_reg[i]} <=
              {1'b0, upper_reg[i]}) begin
            alert_reg[i] <= 1'b0;
          end
        end
      end
    end
  end

  // one cycle behind the flags, but the pin comes from a flop
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      alert_pin_reg <= 1'b0;
    end else begin
      alert_pin_reg <= |alert_reg;
    end
  end

  assign alert_ch_o = alert_reg;
  assign alert_output_pin_o = alert_pin_reg;
endmodule // lsa_dev
`default_nettype wire

//--- rtl/lsa_host.sv
`timescale 1ns/10ps
`default_nettype none
`include "lsa_params.svh"
module lsa_host (
  input wire logic clk_i,
  input wire logic rst_i,
  lsa_i2c_if.host bus,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o
);
  import lsa_pkg::*;

  lsa_mst_st_t st_reg;
  logic sda_f;
  logic [7:0] qcnt_reg;
  logic tick;
  logic [1:0] ph_reg;
  logic [3:0] bit_reg;
  logic [7:0] sh_reg;
  logic [7:0] rx_reg;
  logic byte_reg;
  logic rd_reg;
  logic stop_reg;
  logic nack_mode_reg;
  logic nack_reg;
  logic scl_oe_reg;
  logic sda_oe_reg;
  logic take;
  logic cmd_go;

  lsa_line_filt u_sda_filt (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .line_i(bus.sda),
    .line_o(sda_f)
  );

  assign take = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  // commands arriving while busy are acked but dropped
  assign cmd_go = take & wb_we_i & wb_sel_i[1] &
    (wb_adr_i == `LSA_WB_CMD) & (st_reg == m_idle);
  assign tick = qcnt_reg == 8'(`LSA_QTR_CYC - 1);
  assign bus.scl_oe_m = scl_oe_reg;
  assign bus.sda_oe_m = sda_oe_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= take;
      if (take & ~wb_we_i)
        wb_dat_o <= (wb_adr_i == `LSA_WB_STAT) ?
          {16'h0000, rx_reg, 6'h00, nack_reg, st_reg != m_idle} :
          32'h0000_0000;
    end
  end

  // quarter-bit enable; bit time is four ticks
  always_ff @(posedge clk_i) begin
    if (rst_i || tick)
      qcnt_reg <= 8'h00;
    else
      qcnt_reg <= qcnt_reg + 8'h01;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_reg <= m_idle;
      ph_reg <= 2'h0;
      bit_reg <= 4'h0;
      sh_reg <= 8'h00;
      rx_reg <= 8'h00;
      byte_reg <= 1'b0;
      rd_reg <= 1'b0;
      stop_reg <= 1'b0;
      nack_mode_reg <= 1'b0;
      nack_reg <= 1'b0;
      scl_oe_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
    end else if (cmd_go) begin
      sh_reg <= wb_dat_i[7:0];
      byte_reg <= wb_dat_i[`LSA_CMD_WRITE] | wb_dat_i[`LSA_CMD_READ];
      rd_reg <= wb_dat_i[`LSA_CMD_READ];
      stop_reg <= wb_dat_i[`LSA_CMD_STOP];
      nack_mode_reg <= wb_dat_i[`LSA_CMD_NACK];
      nack_reg <= 1'b0;
      ph_reg <= 2'h0;
      bit_reg <= 4'h0;
      if (wb_dat_i[`LSA_CMD_START])
        st_reg <= m_start;
      else if (wb_dat_i[`LSA_CMD_WRITE] | wb_dat_i[`LSA_CMD_READ])
        st_reg <= m_byte;
      else if (wb_dat_i[`LSA_CMD_STOP])
        st_reg <= m_stop;
    end else if (tick && st_reg != m_idle) begin
      ph_reg <= ph_reg + 2'h1;
      case (st_reg)
        // also works from clock low, giving a repeated start
        m_start: begin
          case (ph_reg)
            2'h0: sda_oe_reg <= 1'b0;
            2'h1: scl_oe_reg <= 1'b0;
            2'h2: sda_oe_reg <= 1'b1;
            default: begin
              scl_oe_reg <= 1'b1;
              st_reg <= byte_reg ? m_byte : (stop_reg ? m_stop : m_idle);
            end
          endcase
        end
        m_byte: begin
          case (ph_reg)
            2'h0: sda_oe_reg <= (bit_reg == `LSA_ACK_BIT) ?
              (rd_reg & ~nack_mode_reg) :
              (~rd_reg & ~sh_reg[7]);
            2'h1: scl_oe_reg <= 1'b0;
            2'h2: begin
              if (bit_reg < `LSA_ACK_BIT)
                rx_reg <= {rx_reg[6:0], sda_f};
              else if (~rd_reg & sda_f)
                nack_reg <= 1'b1;
            end
            default: begin
              scl_oe_reg <= 1'b1;
              sh_reg <= {sh_reg[6:0], 1'b0};
              bit_reg <= bit_reg + 4'h1;
              if (bit_reg == `LSA_ACK_BIT) begin
                // a refused byte abandons the transfer with a stop
                st_reg <= (stop_reg | nack_reg) ? m_stop : m_idle;
                bit_reg <= 4'h0;
              end
            end
          endcase
        end
        m_stop: begin
          case (ph_reg)
            2'h0: sda_oe_reg <= 1'b1;
            2'h1: scl_oe_reg <= 1'b0;
            2'h2: sda_oe_reg <= 1'b0;
            default: st_reg <= m_idle;
          endcase
        end
        default: st_reg <= m_idle;
      endcase
    end
  end
endmodule // lsa_host
`default_nettype wire

//--- rtl/lsa_line_filt.sv
`timescale 1ns/10ps
`default_nettype none
`include "lsa_params.svh"
module lsa_line_filt (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic line_i,
  output logic line_o
);
  logic meta_reg;
  logic sync_reg;
  logic [3:0] cnt_reg;

  always_ff @(posedge clk_i) begin
    meta_reg <= line_i;
    sync_reg <= meta_reg;
  end

  // a level must hold a full spike time before it is believed
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      line_o <= 1'b1;
      cnt_reg <= 4'h0;
    end else if (sync_reg == line_o) begin
      cnt_reg <= 4'h0;
    end else if (cnt_reg == 4'(`LSA_SPIKE_CYC - 1)) begin
      line_o <= sync_reg;
      cnt_reg <= 4'h0;
    end else begin
      cnt_reg <= cnt_reg + 4'h1;
    end
  end
endmodule // lsa_line_filt
`default_nettype wire
